// File: src/cio_core.v
// processor i/o facilities, bus cycle engine and vectored interrupt
//
// Summary of operation
// - flag output pin always equals the status word flag bit.
// - status load/preset/clear updates flag in the instruction's last cycle.
// - sense pin mirrors into a status bit, readable any time.
// - data and control byte i/o differ only in data/control select.
// - byte i/o: io, non-extended, select valid, address meaningless.
// - cycle type encoding for memory, extended and one-byte cycles.
// - extended read puts device address on low lines, latches data.
// - extended write shows device address and drives register byte.
// - extended address held all through request; select meaningless.
// - one active-low request, single level, 8-bit vector, 128 targets.
// - vector top bit requests an indirect address sequence.
// - accepting an interrupt sets the inhibit bit.
// - inhibit set: interrupt request input ignored.
// - inhibit set by load/preset, cleared by reset, clear/load, return with return enable.
// - current instruction completes before the interrupt sequence.
// - jammed zero-page branch-to-subroutine replaces next instruction.
// - vector byte fetched in a cycle marked by interrupt acknowledge.
// - branch pushes next address, continues at zero plus offset.
// - return pops the saved address, program resumes there.
// - request held until acknowledge low; responder releases after.
// - data/control select low for control, high for data.
`timescale 1ns/10ps
`include "cio_regs.vh"
module cio_core (
  input  wire        clk_sys_in,
  input  wire        reset_n_in,
  // execution unit side
  input  wire        cyc_start_in,
  input  wire [2:0]  cyc_kind_in,
  input  wire        cyc_write_in,
  input  wire        cyc_data_sel_in,
  input  wire [14:0] cyc_addr_in,
  input  wire [7:0]  cyc_wdata_in,
  input  wire        last_cycle_in,
  input  wire        psu_load_in,
  input  wire        psu_preset_in,
  input  wire        psu_clear_in,
  input  wire [7:0]  psu_operand_in,
  input  wire        ret_in,
  input  wire        ret_enable_in,
  input  wire        bsr_in,
  input  wire [14:0] bsr_next_addr_in,
  output wire        cyc_busy_out,
  output reg         cyc_done_out,
  output reg  [7:0]  cyc_rdata_out,
  output reg  [7:0]  psu_out,
  output reg         int_pending_out,
  output reg         jam_out,
  output reg         vec_indirect_out,
  output reg  [14:0] vec_target_out,
  output reg         ret_valid_out,
  output reg  [14:0] ret_addr_out,
  // pins
  input  wire        sense_in,
  input  wire        interrupt_request_n_in,
  input  wire        operation_acknowledge_n_in,
  input  wire [7:0]  data_bus_lines_in,
  output reg  [7:0]  data_bus_lines_out,
  output reg         data_bus_lines_oe_out,
  output reg  [12:0] addr_out,
  output reg         addr13_or_extended_select_out,
  output reg         addr14_or_data_control_select_out,
  output reg         operation_request_out,
  output reg         memory_io_out,
  output reg         read_write_out,
  output reg         interrupt_acknowledge_out,
  output wire        flag_out
);

  // sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [1:0]  sense_sync;
  reg [1:0]  irq_sync;
  reg [1:0]  ack_sync;
  // data bus synced as well; it settles before the acknowledge, which
  // reaches the sequencer through the same two flops
  reg [7:0]  dbus_meta;
  reg [7:0]  dbus_sync;
  reg [1:0]  state;
  reg [2:0]  kind;
  wire [14:0] ras [0:`CIO_RAS_DEPTH-1];
  reg [2:0]  ras_ptr;
  reg [14:0] next_target;
  wire       irq_seen;
  wire       ack_low;

  assign ack_low  = ~ack_sync[1];
  assign irq_seen = ~irq_sync[1] & ~psu_out[`CIO_PSU_INH];
  assign flag_out = psu_out[`CIO_PSU_FLAG];
  assign cyc_busy_out = (state != ST_IDLE);

  // pins cross into the clock domain before any use
  always @(posedge clk_sys_in) begin
    sense_sync <= {sense_sync[0], sense_in};
    irq_sync   <= {irq_sync[0], interrupt_request_n_in};
    ack_sync   <= {ack_sync[0], operation_acknowledge_n_in};
    dbus_meta  <= data_bus_lines_in;
    dbus_sync  <= dbus_meta;
  end

  // vector: bit 7 indirect, 6:0 signed offset from zero, wrap in page
  always @* begin
    next_target = {{8{dbus_sync[6]}}, dbus_sync[6:0]}
                  & `CIO_PAGE_MASK;
  end

  // acceptance: synced request, inhibit clear, last cycle of instruction
  function accept_now;
    input last;
    input seen;
    begin
      accept_now = last & seen;
    end
  endfunction

  // status word upper byte
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      psu_out <= 8'h00;
    end else begin
      psu_out[`CIO_PSU_SENSE] <= sense_sync[1];
      if (last_cycle_in) begin
        if (psu_load_in) begin
          psu_out[`CIO_PSU_FLAG] <= psu_operand_in[`CIO_PSU_FLAG];
          psu_out[`CIO_PSU_INH]  <= psu_operand_in[`CIO_PSU_INH];
          psu_out[4:0]           <= psu_operand_in[4:0];
        end else if (psu_preset_in) begin
          psu_out[6:0] <= psu_out[6:0] | psu_operand_in[6:0];
        end else if (psu_clear_in) begin
          psu_out[6:0] <= psu_out[6:0] & ~psu_operand_in[6:0];
        end
        if (ret_in && ret_enable_in)
          psu_out[`CIO_PSU_INH] <= 1'h0;
      end
      // acceptance wins over any clear in the same cycle
      if (accept_now(last_cycle_in, irq_seen))
        psu_out[`CIO_PSU_INH] <= 1'h1;
    end
  end

  // interrupt acceptance only at instruction end; jam replaces fetch
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      int_pending_out <= 1'h0;
      jam_out         <= 1'h0;
    end else begin
      int_pending_out <= irq_seen;
      jam_out         <= accept_now(last_cycle_in, irq_seen);
    end
  end

  // bus cycle engine: request held until acknowledge low
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state                             <= ST_IDLE;
      kind                              <= `CIO_KIND_MEM;
      operation_request_out             <= 1'h0;
      memory_io_out                     <= `CIO_MIO_MEM;
      read_write_out                    <= 1'h0;
      addr_out                          <= 13'h0000;
      addr13_or_extended_select_out     <= 1'h0;
      addr14_or_data_control_select_out <= 1'h0;
      data_bus_lines_out                <= 8'h00;
      data_bus_lines_oe_out             <= 1'h0;
      interrupt_acknowledge_out         <= 1'h0;
      cyc_done_out                      <= 1'h0;
      cyc_rdata_out                     <= 8'h00;
      vec_indirect_out                  <= 1'h0;
      vec_target_out                    <= `CIO_RESET_ADDR;
    end else begin
      cyc_done_out <= 1'h0;
      case (state)
        ST_IDLE: begin
          if (cyc_start_in) begin
            kind                  <= cyc_kind_in;
            operation_request_out <= 1'h1;
            read_write_out        <= cyc_write_in;
            data_bus_lines_out    <= cyc_wdata_in;
            data_bus_lines_oe_out <= cyc_write_in;
            interrupt_acknowledge_out <= 1'h0;
            case (cyc_kind_in)
              `CIO_KIND_IO1: begin
                memory_io_out                 <= `CIO_MIO_IO;
                addr13_or_extended_select_out <= `CIO_SEL_NONEXT;
                addr14_or_data_control_select_out
                  <= cyc_data_sel_in;
                addr_out <= 13'h0000;
              end
              `CIO_KIND_EXT: begin
                memory_io_out                 <= `CIO_MIO_IO;
                addr13_or_extended_select_out <= `CIO_SEL_EXT;
                addr14_or_data_control_select_out <= 1'h0;
                addr_out <= {5'h00, cyc_addr_in[7:0]};
              end
              `CIO_KIND_VEC: begin
                // vector fetch carries acknowledge; peripheral answers
                memory_io_out  <= `CIO_MIO_MEM;
                read_write_out <= 1'h0;
                data_bus_lines_oe_out <= 1'h0;
                addr13_or_extended_select_out     <= 1'h0;
                addr14_or_data_control_select_out <= 1'h0;
                addr_out <= 13'h0000;
                interrupt_acknowledge_out <= 1'h1;
              end
              default: begin
                memory_io_out <= `CIO_MIO_MEM;
                addr_out      <= cyc_addr_in[12:0];
                addr13_or_extended_select_out     <= cyc_addr_in[13];
                addr14_or_data_control_select_out <= cyc_addr_in[14];
              end
            endcase
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (ack_low) begin
            operation_request_out <= 1'h0;
            data_bus_lines_oe_out <= 1'h0;
            cyc_rdata_out         <= dbus_sync;
            cyc_done_out          <= 1'h1;
            if (kind == `CIO_KIND_VEC) begin
              vec_indirect_out <= dbus_sync[7];
              vec_target_out   <= next_target;
            end
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          // wait for responder to release before the next request
          if (!ack_low) begin
            interrupt_acknowledge_out <= 1'h0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // return address stack, eight levels, circular pointer
  genvar gi;
  generate
    for (gi = 0; gi < `CIO_RAS_DEPTH; gi = gi + 1) begin : g_ras
      localparam [2:0] SLOT = gi;
      reg [14:0] entry;
      assign ras[gi] = entry;
      always @(posedge clk_sys_in) begin
        if (!reset_n_in)
          entry <= `CIO_RESET_ADDR;
        else if (bsr_in && (ras_ptr + 3'h1) == SLOT)
          entry <= bsr_next_addr_in;
      end
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ras_ptr       <= 3'h0;
      ret_valid_out <= 1'h0;
      ret_addr_out  <= `CIO_RESET_ADDR;
    end else begin
      ret_valid_out <= 1'h0;
      // a ninth push wraps and overwrites the oldest return address
      if (bsr_in) begin
        ras_ptr <= ras_ptr + 3'h1;
      end else if (ret_in) begin
        ret_addr_out  <= ras_read(ras_ptr);
        ret_valid_out <= 1'h1;
        ras_ptr       <= ras_ptr - 3'h1;
      end
    end
  end

  function [14:0] ras_read;
    input [2:0] p;
    begin
      case (p)
        3'h0: ras_read = ras[0];
        3'h1: ras_read = ras[1];
        3'h2: ras_read = ras[2];
        3'h3: ras_read = ras[3];
        3'h4: ras_read = ras[4];
        3'h5: ras_read = ras[5];
        3'h6: ras_read = ras[6];
        default: ras_read = ras[7];
      endcase
    end
  endfunction

endmodule

// File: src/cio_regs.vh
// constants for the processor i/o and interrupt interface
`ifndef CIO_REGS_VH
`define CIO_REGS_VH
// bus cycle kinds requested by the sequencer
`define CIO_KIND_MEM      3'h0
`define CIO_KIND_IO1      3'h1
`define CIO_KIND_EXT      3'h2
`define CIO_KIND_VEC      3'h3
`define CIO_KIND_W        3
// status word bit positions (upper byte)
`define CIO_PSU_SENSE     7
`define CIO_PSU_FLAG      6
`define CIO_PSU_INH       5
// memory/io and select line levels
`define CIO_MIO_MEM       1'h1
`define CIO_MIO_IO        1'h0
`define CIO_SEL_DATA      1'h1
`define CIO_SEL_CTRL      1'h0
`define CIO_SEL_EXT       1'h1
`define CIO_SEL_NONEXT    1'h0
// return address stack, address width, page mask and reset address
`define CIO_RAS_DEPTH     8
`define CIO_RAS_PTR_W     3
`define CIO_ADDR_W        15
`define CIO_PAGE_MASK     15'h1FFF
`define CIO_RESET_ADDR    15'h0000
`endif

// File: bench/cio_core_assertions.sv
// concurrent checks on the i/o and interrupt core ports
`timescale 1ns/10ps
`include "cio_regs.vh"
module cio_core_chk (
  input wire        clk_sys_in,
  input wire        reset_n_in,
  input wire        cyc_start_in,
  input wire [2:0]  cyc_kind_in,
  input wire        cyc_write_in,
  input wire        cyc_data_sel_in,
  input wire [14:0] cyc_addr_in,
  input wire        cyc_busy_out,
  input wire        cyc_done_out,
  input wire [7:0]  psu_out,
  input wire        jam_out,
  input wire        sense_in,
  input wire        operation_acknowledge_n_in,
  input wire [12:0] addr_out,
  input wire        addr13_or_extended_select_out,
  input wire        addr14_or_data_control_select_out,
  input wire        operation_request_out,
  input wire        memory_io_out,
  input wire        read_write_out,
  input wire        interrupt_acknowledge_out,
  input wire        flag_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  wire take = cyc_start_in && !cyc_busy_out;
  // two sync flops plus one state edge before the request can drop
  sequence s_ack_low;
    operation_request_out && $fell(operation_acknowledge_n_in);
  endsequence
  sequence s_closed;
    !operation_request_out && cyc_done_out;
  endsequence
  a_flag_pin_copy: assert property (flag_out == psu_out[6])
    else $error("flag pin wrong");
  a_sense_mirror: assert property (
    $stable(sense_in) [*5] |-> psu_out[7] == sense_in)
    else $error("sense bit wrong");
  a_byte_io_lines: assert property (
    take && cyc_kind_in == `CIO_KIND_IO1 |=> operation_request_out
      && memory_io_out == `CIO_MIO_IO
      && addr13_or_extended_select_out == `CIO_SEL_NONEXT
      && addr14_or_data_control_select_out == $past(cyc_data_sel_in)
      && read_write_out == $past(cyc_write_in))
    else $error("byte cycle lines wrong");
  a_ext_dev_addr: assert property (
    take && cyc_kind_in == `CIO_KIND_EXT |=> operation_request_out
      && memory_io_out == `CIO_MIO_IO
      && addr13_or_extended_select_out == `CIO_SEL_EXT
      && addr_out[7:0] == $past(cyc_addr_in[7:0]))
    else $error("device address wrong");
  a_ext_addr_hold: assert property (
    operation_request_out && addr13_or_extended_select_out && !memory_io_out
      ##1 operation_request_out |-> $stable(addr_out[7:0]))
    else $error("device address moved");
  a_req_close: assert property (s_ack_low |-> ##[1:4] s_closed)
    else $error("request not closed");
  a_inhibit_blocks: assert property ($past(psu_out[5]) |-> !jam_out)
    else $error("accepted while inhibited");
  a_vector_interrupt_acknowledge: assert property (
    take && cyc_kind_in == `CIO_KIND_VEC |=> operation_request_out
      && interrupt_acknowledge_out && !read_write_out)
    else $error("vector fetch unmarked");
endmodule
bind cio_core cio_core_chk u_chk (.*);

// File: bench/cio_far_end.sv
// far-side model: memory, i/o devices and interrupting peripheral
`timescale 1ns/10ps
module cio_far_end (
  input  wire       clk_sys_in,
  input  wire       req_in,
  input  wire       interrupt_acknowledge_in,
  input  wire [7:0] rbyte_in,
  input  wire [7:0] vector_in,
  input  wire [7:0] delay_in,
  output reg        ack_n_out = 1'h1,
  output reg  [7:0] dbus_out = 8'h00
);
  integer cnt = 0;
  // every cycle kind is answered the way memory answers, except that a cycle with interrupt acknowledge gets vector_in
  always @(posedge clk_sys_in) begin
    #1;
    if (req_in && ack_n_out) begin
      cnt = cnt + 1;
      if (cnt > delay_in) begin
        ack_n_out = 1'h0;
        dbus_out = interrupt_acknowledge_in ? vector_in : rbyte_in;
      end
    end else if (!req_in && !ack_n_out) begin
      ack_n_out = 1'h1;
      dbus_out = ~dbus_out; // released bus must not look held
      cnt = 0;
    end
  end
endmodule

// File: bench/test_cpu_io_and_interrupt_interface.sv
// self-checking bench for the i/o and interrupt core
`timescale 1ns/10ps
`include "cio_regs.vh"
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
  end \
end
module test_cpu_io_and_interrupt_interface;
  logic clk_sys_in, reset_n_in, cyc_start_in, cyc_write_in, cyc_data_sel_in;
  logic last_cycle_in, psu_load_in, psu_preset_in, psu_clear_in, ret_in;
  logic ret_enable_in, bsr_in, sense_in, interrupt_request_n_in, flag_out;
  logic cyc_busy_out, cyc_done_out, int_pending_out, jam_out, ret_valid_out;
  logic vec_indirect_out, data_bus_lines_oe_out, operation_request_out;
  logic addr13_or_extended_select_out, addr14_or_data_control_select_out;
  logic memory_io_out, read_write_out, interrupt_acknowledge_out;
  logic operation_acknowledge_n_in;
  logic [2:0]  cyc_kind_in;
  logic [5:0]  snap;
  logic [7:0]  cyc_wdata_in, psu_operand_in, cyc_rdata_out, psu_out, wd;
  logic [7:0]  data_bus_lines_in, data_bus_lines_out, rbyte, vector, dly;
  logic [7:0]  far_dbus, e;
  logic [12:0] addr_out, adr;
  logic [14:0] cyc_addr_in, bsr_next_addr_in, vec_target_out, ret_addr_out;
  logic [7:0]  vecs [3] = '{8'h85, 8'h40, 8'h7F};
  logic [15:0] tgts [3] = '{16'h8005, 16'h1FC0, 16'h1FFF};
  int          fails = 0, n_checks = 0, cycles = 0, jams = 0, i, j;
  cio_core dut (.*);
  cio_far_end far (
    .clk_sys_in (clk_sys_in),
    .req_in     (operation_request_out),
    .interrupt_acknowledge_in  (interrupt_acknowledge_out),
    .rbyte_in   (rbyte),
    .vector_in  (vector),
    .delay_in   (dly),
    .ack_n_out  (operation_acknowledge_n_in),
    .dbus_out   (far_dbus)
  );
  assign data_bus_lines_in = data_bus_lines_oe_out ? data_bus_lines_out
                                                   : far_dbus;
  initial begin
    clk_sys_in = 1'h0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    jams += (jam_out === 1'h1);
    if (cycles == 2000) begin
      fails++;
      results();
    end
  end
  task results();
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task bus(input logic [2:0] k, input logic w, s, input logic [14:0] a,
           input logic [7:0] d);
    cyc_kind_in = k;
    cyc_write_in = w;
    cyc_data_sel_in = s;
    cyc_addr_in = a;
    cyc_wdata_in = d;
    cyc_start_in = 1'h1;
    tick(1);
    cyc_start_in = 1'h0;
    snap = {operation_request_out, memory_io_out, read_write_out,
            addr13_or_extended_select_out,
            addr14_or_data_control_select_out, interrupt_acknowledge_out};
    adr = addr_out;
    wd = data_bus_lines_in;
    for (i = 0; i < 100 && cyc_done_out !== 1'h1; i++) tick(1);
    `CHK(cyc_done_out, 1'h1)
    if (w) `CHK(wd, d)
    else `CHK(cyc_rdata_out, k == `CIO_KIND_VEC ? vector : rbyte)
    for (i = 0; i < 100 && cyc_busy_out !== 1'h0; i++) tick(1);
    `CHK(cyc_busy_out, 1'h0)
  endtask
  initial begin
    {cyc_start_in, cyc_write_in, cyc_data_sel_in, last_cycle_in, psu_load_in,
     psu_preset_in, psu_clear_in, ret_in, ret_enable_in, bsr_in, sense_in,
     reset_n_in} = '0;
    {cyc_kind_in, cyc_addr_in, cyc_wdata_in, psu_operand_in} = '0;
    {bsr_next_addr_in, vector, dly} = '0;
    interrupt_request_n_in = 1'h1;
    rbyte = 8'h3C;
    tick(10);
    reset_n_in = 1'h1;
    `CHK({operation_request_out, memory_io_out, psu_out[6:5]}, 4'h4)
    psu_operand_in = 8'h40;
    psu_preset_in = 1'h1;
    tick(2);
    `CHK(flag_out, 1'h0)
    last_cycle_in = 1'h1;
    tick(1);
    psu_preset_in = 1'h0;
    `CHK(flag_out, 1'h1)
    psu_clear_in = 1'h1;
    tick(1);
    psu_clear_in = 1'h0;
    `CHK(flag_out, 1'h0)
    psu_operand_in = 8'h20;
    psu_load_in = 1'h1;
    tick(1);
    psu_load_in = 1'h0;
    `CHK(psu_out[6:5], 2'h1)
    for (j = 0; j < 2; j++) begin
      sense_in = ~j[0];
      tick(5);
      `CHK(psu_out[7], ~j[0])
    end
    for (j = 0; j < 4; j++) begin
      rbyte = 8'hA0 ^ j[7:0];
      bus(`CIO_KIND_IO1, j[1], j[0], 15'h7FFF, 8'h5A ^ j[7:0]);
      `CHK(snap, {2'h2, j[1], `CIO_SEL_NONEXT, j[0], 1'h0})
    end
    for (j = 0; j < 2; j++) begin
      e = 8'hC3 ^ {8{j[0]}};
      bus(`CIO_KIND_EXT, j[0], 1'h0, {7'h00, e}, 8'h69);
      `CHK({snap[5:4], snap[2], adr[7:0]}, {3'h5, e})
    end
    dly = 8'h14;
    bus(`CIO_KIND_MEM, 1'h1, 1'h0, 15'h6123, 8'hE7);
    `CHK({snap, adr}, {6'h3E, 13'h0123})
    dly = 8'h00;
    interrupt_request_n_in = 1'h0;
    tick(20);
    `CHK(int_pending_out, 1'h0)
    {ret_in, ret_enable_in} = 2'h3;
    tick(1);
    {ret_in, ret_enable_in} = 2'h0;
    last_cycle_in = 1'h0;
    `CHK(psu_out[5], 1'h0)
    tick(10);
    `CHK(jams, 0)
    `CHK(int_pending_out, 1'h1)
    last_cycle_in = 1'h1;
    tick(3);
    `CHK(jams, 1)
    `CHK(psu_out[5], 1'h1)
    for (j = 0; j < 3; j++) begin
      vector = vecs[j];
      bus(`CIO_KIND_VEC, 1'h0, 1'h0, 15'h0000, 8'h00);
      `CHK(snap, 6'h31)
      `CHK({vec_indirect_out, vec_target_out}, tgts[j])
    end
    interrupt_request_n_in = 1'h1;
    for (j = 0; j < 4; j++) begin
      bsr_next_addr_in = 15'h1230 + j[14:0];
      {bsr_in, ret_in} = j < 2 ? 2'h2 : 2'h1;
      tick(1);
      {bsr_in, ret_in} = 2'h0;
      for (i = 0; i < 4 && j > 1 && ret_valid_out !== 1'h1; i++) tick(1);
      if (j > 1) `CHK(ret_addr_out, 15'h1233 - j[14:0])
      tick(1);
    end
    results();
  end
endmodule
